// ### pkg/rspc_pkg.sv
// Package with constants, types and register map of the return stack and counter unit.
package rspc_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int DEPTH = 31;
  localparam int ADDR_W = 4;
  localparam logic [4:0] SP_MAX = 5'h1f;
  localparam logic [4:0] SP_ZERO = 5'h00;
  localparam logic [20:0] PC_RESET = 21'h00_0000;
  localparam logic [20:0] PC_STEP = 21'h00_0002;
  localparam logic [20:0] PC_ALIGN_MASK = 21'h1f_fffe;
  localparam int FULL_BIT = 7;
  localparam int UNDER_BIT = 6;
  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_STACK_PTR = 4'h0;
  localparam logic [3:0] ADDR_TOP_LOW = 4'h1;
  localparam logic [3:0] ADDR_TOP_HIGH = 4'h2;
  localparam logic [3:0] ADDR_TOP_UPPER = 4'h3;
  localparam logic [3:0] ADDR_PC_LOW = 4'h4;
  localparam logic [3:0] ADDR_PC_HIGH_LATCH = 4'h5;
  localparam logic [3:0] ADDR_PC_UPPER_LATCH = 4'h6;
  localparam logic [3:0] ADDR_CONFIG = 4'h7;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic ERR_RESET_DEFAULT = 1'b1;

  typedef enum logic [2:0] {
    RSPC_OP_NONE = 3'b000,
    RSPC_OP_CALL = 3'b001,
    RSPC_OP_RETURN = 3'b010,
    RSPC_OP_PUSH = 3'b011,
    RSPC_OP_POP = 3'b100,
    RSPC_OP_JUMP = 3'b101,
    RSPC_OP_STEP = 3'b110,
    RSPC_OP_HOLD = 3'b111
  } rspc_op_t;

  typedef struct packed {
    rspc_op_t op;
    logic [20:0] target;
    logic irq_vector;
    logic fast_return;
  } rspc_cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working;
    logic [7:0] bank;
  } rspc_ctx_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rspc_bus_t;
endpackage

// ### verilog/rspc_stack_mem.sv
// Flip-flop storage for the return stack entries, addressed by the stack pointer.
`timescale 1ns/100ps
module rspc_stack_mem #(
  parameter int DEPTH = 31,
  parameter int WIDTH = 21
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [4:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  import rspc_pkg::*;
  typedef struct packed {
    logic [DEPTH:1][WIDTH-1:0] mem;
  } rspc_mem_state_t;
  rspc_mem_state_t state;
  rspc_mem_state_t next_state;

  always_comb begin
    next_state = state;
    for (int i = 1; i <= DEPTH; i++) begin
      if (wr_en && wr_idx == i[4:0]) begin
        next_state.mem[i] = wr_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Index zero has no storage and always reads as zero.
  always_comb begin
    rd_data = '0;
    if (rd_idx != SP_ZERO) begin
      rd_data = state.mem[rd_idx];
    end
  end
endmodule

// ### verilog/rspc_shadow.sv
// Single-level shadow copy of status, working and bank-select registers.
`timescale 1ns/100ps
module rspc_shadow (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic load,
  input wire rspc_pkg::rspc_ctx_t ctx_in,
  output rspc_pkg::rspc_ctx_t ctx_out
);
  import rspc_pkg::*;
  rspc_ctx_t state;
  rspc_ctx_t next_state;

  always_comb begin
    next_state = state;
    if (load) begin
      next_state = ctx_in;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ctx_out = state;
endmodule

// ### verilog/rspc_unit.sv
// Return address stack, shadow registers and program counter of the core.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module rspc_unit #(
  parameter int DEPTH = rspc_pkg::DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic por_rst,
  input wire logic stack_error_reset_enable,
  input wire rspc_pkg::rspc_cmd_t cmd,
  input wire rspc_pkg::rspc_ctx_t ctx_in,
  input wire rspc_pkg::rspc_bus_t bus,
  output rspc_pkg::rspc_ctx_t ctx_restore,
  output logic ctx_restore_valid,
  output logic [20:0] pc,
  output logic [7:0] rdata,
  output logic device_reset_req
);
  import rspc_pkg::*;

  typedef struct packed {
    logic [20:0] pc;
    logic [4:0] sp;
    logic full;
    logic under;
    logic [7:0] high_latch;
    logic [4:0] upper_latch;
    logic [7:0] rdata;
    logic reset_req;
    logic restore_valid;
    rspc_ctx_t restore;
  } rspc_state_t;

  rspc_state_t state;
  rspc_state_t next_state;
  logic mem_wr;
  logic [4:0] mem_idx;
  logic [20:0] mem_wdata;
  logic [20:0] top_entry;
  rspc_ctx_t shadow_ctx;
  logic pc_low_write;
  logic pc_low_read;
  logic top_write;

  // Stack entries survive a device reset, so software can inspect them after a stack error.
  rspc_stack_mem #(.DEPTH(DEPTH), .WIDTH(PC_W)) u_mem (
    .clock(clock),
    .sys_rst(por_rst),
    .wr_en(mem_wr),
    .wr_idx(mem_idx),
    .wr_data(mem_wdata),
    .rd_idx(state.sp),
    .rd_data(top_entry)
  );

  rspc_shadow u_shadow (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(cmd.irq_vector),
    .ctx_in(ctx_in),
    .ctx_out(shadow_ctx)
  );

  assign pc_low_write = bus.wr && bus.addr == ADDR_PC_LOW;
  assign pc_low_read = bus.rd && bus.addr == ADDR_PC_LOW;
  assign top_write = bus.wr && (bus.addr == ADDR_TOP_LOW || bus.addr == ADDR_TOP_HIGH ||
                                bus.addr == ADDR_TOP_UPPER);

  always_comb begin
    logic push;
    logic pop;
    logic hw_full;
    logic hw_under;
    logic [20:0] pc_next;
    push = 1'b0;
    pop = 1'b0;
    hw_full = 1'b0;
    hw_under = 1'b0;
    pc_next = state.pc;
    next_state = state;
    next_state.reset_req = 1'b0;
    next_state.restore_valid = 1'b0;
    next_state.rdata = READ_ZERO;
    mem_wr = 1'b0;
    mem_idx = state.sp;
    mem_wdata = state.pc;

    // Interrupt acknowledge is issued as RSPC_OP_CALL to the vector; cmd.irq_vector itself only loads the shadow.
    case (cmd.op)
      RSPC_OP_CALL: begin
        push = 1'b1;
        pc_next = cmd.target;
      end
      RSPC_OP_PUSH: begin
        push = 1'b1;
      end
      RSPC_OP_RETURN: begin
        pop = 1'b1;
        pc_next = top_entry;
        if (state.sp == SP_ZERO) begin
          pc_next = PC_RESET;
        end
        if (cmd.fast_return) begin
          next_state.restore = shadow_ctx;
          next_state.restore_valid = 1'b1;
        end
      end
      RSPC_OP_POP: begin
        pop = 1'b1;
      end
      RSPC_OP_JUMP: begin
        pc_next = cmd.target;
      end
      RSPC_OP_STEP: begin
        pc_next = state.pc + PC_STEP;
      end
      default: begin
        pc_next = state.pc;
      end
    endcase

    if (push) begin
      if (state.sp == SP_MAX) begin
        hw_full = 1'b1;
      end else begin
        next_state.sp = state.sp + 5'h01;
        mem_idx = next_state.sp;
        mem_wr = 1'b1;
        if (next_state.sp == SP_MAX) begin
          hw_full = 1'b1;
          if (stack_error_reset_enable) begin
            mem_wdata = state.pc + PC_STEP;
          end
        end
      end
    end else if (pop) begin
      if (state.sp == SP_ZERO) begin
        hw_under = 1'b1;
      end else begin
        next_state.sp = state.sp - 5'h01;
      end
    end

    // Software access; the write happens before hardware flag sets.
    if (bus.wr) begin
      if (bus.addr == ADDR_STACK_PTR) begin
        next_state.sp = bus.wdata[SP_W-1:0];
        if (!bus.wdata[FULL_BIT]) next_state.full = 1'b0;
        if (!bus.wdata[UNDER_BIT]) next_state.under = 1'b0;
      end else if (bus.addr == ADDR_PC_HIGH_LATCH) begin
        next_state.high_latch = bus.wdata;
      end else if (bus.addr == ADDR_PC_UPPER_LATCH) begin
        next_state.upper_latch = bus.wdata[4:0];
      end else if (bus.addr == ADDR_PC_LOW) begin
        pc_next = {state.upper_latch, state.high_latch, bus.wdata};
      end
    end
    if (top_write && !mem_wr) begin
      mem_wr = 1'b1;
      mem_idx = state.sp;
      mem_wdata = top_entry;
      if (bus.addr == ADDR_TOP_LOW) mem_wdata[7:0] = bus.wdata;
      else if (bus.addr == ADDR_TOP_HIGH) mem_wdata[15:8] = bus.wdata;
      else mem_wdata[20:16] = bus.wdata[4:0];
    end

    if (bus.rd) begin
      if (bus.addr == ADDR_STACK_PTR) begin
        next_state.rdata = {state.full, state.under, 1'b0, state.sp};
      end else if (bus.addr == ADDR_TOP_LOW) begin
        next_state.rdata = top_entry[7:0];
      end else if (bus.addr == ADDR_TOP_HIGH) begin
        next_state.rdata = top_entry[15:8];
      end else if (bus.addr == ADDR_TOP_UPPER) begin
        next_state.rdata = {3'b000, top_entry[20:16]};
      end else if (bus.addr == ADDR_PC_LOW) begin
        next_state.rdata = state.pc[7:0];
        next_state.high_latch = state.pc[15:8];
        next_state.upper_latch = state.pc[20:16];
      end else if (bus.addr == ADDR_PC_HIGH_LATCH) begin
        next_state.rdata = state.high_latch;
      end else if (bus.addr == ADDR_PC_UPPER_LATCH) begin
        next_state.rdata = {3'b000, state.upper_latch};
      end else if (bus.addr == ADDR_CONFIG) begin
        next_state.rdata = {7'h00, stack_error_reset_enable};
      end else begin
        next_state.rdata = READ_ZERO;
      end
    end

    if (hw_full) next_state.full = 1'b1;
    if (hw_under) next_state.under = 1'b1;
    if ((hw_full || hw_under) && stack_error_reset_enable) begin
      next_state.reset_req = 1'b1;
    end
    next_state.pc = pc_next & PC_ALIGN_MASK;
  end

  // A full-stack reset arrives as sys_rst, which must keep the flags; only por clears them.
  always_ff @(posedge clock) begin
    if (por_rst) begin
      state <= '0;
    end else if (sys_rst) begin
      state.pc <= PC_RESET;
      state.sp <= SP_ZERO;
      state.high_latch <= '0;
      state.upper_latch <= '0;
      state.rdata <= READ_ZERO;
      state.reset_req <= 1'b0;
      state.restore_valid <= 1'b0;
      state.restore <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pc = state.pc;
  assign rdata = state.rdata;
  assign device_reset_req = state.reset_req;
  assign ctx_restore = state.restore;
  assign ctx_restore_valid = state.restore_valid;
endmodule

// ### verification/rspc_unit_checker.sv
// Port assertions for the return stack and counter unit.
`timescale 1ns/100ps
module rspc_unit_checker #(
  parameter int DEPTH = 31
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic por_rst,
  input wire logic stack_error_reset_enable,
  input wire rspc_pkg::rspc_cmd_t cmd,
  input wire rspc_pkg::rspc_bus_t bus,
  input wire logic ctx_restore_valid,
  input wire logic [20:0] pc,
  input wire logic [7:0] rdata,
  input wire logic device_reset_req
);
  import rspc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst || por_rst);
  sequence rd_of(logic [3:0] a);
    bus.rd && bus.addr == a;
  endsequence
  property p_load;
    logic [20:0] t;
    (cmd.op inside {RSPC_OP_JUMP, RSPC_OP_CALL} && !bus.wr, t = cmd.target)
      |=> pc[20:1] == t[20:1];
  endproperty
  property p_low_wr;
    logic [7:0] d;
    (bus.wr && bus.addr == ADDR_PC_LOW, d = bus.wdata) |=> pc[7:0] == (d & 8'hfe);
  endproperty
  pc_align_a: assert property (pc[0] == 1'b0)
    else $error("pc bit 0 set");
  pc_step_a: assert property (cmd.op == RSPC_OP_STEP && !bus.wr |=> pc == $past(pc) + PC_STEP)
    else $error("pc step wrong");
  direct_load_a: assert property (p_load)
    else $error("pc load wrong");
  low_write_a: assert property (p_low_wr)
    else $error("pc low write wrong");
  low_read_a: assert property (rd_of(ADDR_PC_LOW) |=> rdata == 8'($past(pc)))
    else $error("pc low read wrong");
  rdata_idle_a: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("read data without read");
  bit5_zero_a: assert property (rd_of(ADDR_STACK_PTR) |=> rdata[5] == 1'b0)
    else $error("pointer bit 5 set");
  unmapped_zero_a: assert property (bus.rd && bus.addr > ADDR_CONFIG |=> rdata == READ_ZERO)
    else $error("unmapped read not zero");
  fast_ret_a: assert property (cmd.op == RSPC_OP_RETURN && cmd.fast_return |=> ctx_restore_valid)
    else $error("fast return missing");
  // The request drives the device reset itself, so these ignore the device reset.
  no_reset_req_a: assert property (disable iff (por_rst) !stack_error_reset_enable |=> !device_reset_req)
    else $error("reset request while disabled");
  reset_pulse_a: assert property (disable iff (por_rst) device_reset_req |=> !device_reset_req)
    else $error("reset request longer than one cycle");
  error_reset_a: assert property (disable iff (por_rst) device_reset_req |=> pc == PC_RESET)
    else $error("pc not cleared by stack error reset");
endmodule

// ### verification/rspc_core_model.sv
// Core reset model that turns a stack error request into a device reset.
`timescale 1ns/100ps
module rspc_core_model (
  input wire logic bench_rst,
  input wire logic device_reset_req,
  output logic sys_rst
);
  // The request is already a registered pulse, so an OR gives a one-edge reset.
  assign sys_rst = bench_rst | device_reset_req;
endmodule

// ### verification/tb_rspc_unit.sv
// Self-checking testbench for the return stack and counter unit.
`timescale 1ns/100ps
module tb_rspc_unit;
  import rspc_pkg::*;
  logic clock = 1'b0;
  logic bench_rst = 1'b1;
  logic por_rst = 1'b1;
  logic en = 1'b0;
  logic sys_rst;
  logic rst_req;
  logic ctx_v;
  logic [20:0] pc;
  logic [7:0] rdata;
  rspc_cmd_t cmd = '0;
  rspc_ctx_t ctx_in = '0;
  rspc_ctx_t ctx_r;
  rspc_bus_t bus = '0;
  int fails = 0;
  int n_compared = 0;
  int k;
  always #5 clock = ~clock;
  rspc_core_model i_core (
    .bench_rst(bench_rst),
    .device_reset_req(rst_req),
    .sys_rst(sys_rst)
  );
  rspc_unit i_dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .por_rst(por_rst),
    .stack_error_reset_enable(en),
    .cmd(cmd),
    .ctx_in(ctx_in),
    .bus(bus),
    .ctx_restore(ctx_r),
    .ctx_restore_valid(ctx_v),
    .pc(pc),
    .rdata(rdata),
    .device_reset_req(rst_req)
  );
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every signal is assigned once per cycle, so no strobe is written twice in a step.
  task automatic cyc(input rspc_op_t o, input logic [20:0] t, input logic [3:0] a,
                     input logic [7:0] d, input logic w, input logic r);
    cmd.op <= o;
    cmd.target <= t;
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= w;
    bus.rd <= r;
    @(posedge clock);
    #1;
  endtask
  task automatic op(input rspc_op_t o, input logic [20:0] t);
    cyc(o, t, 4'h0, 8'h00, 1'b0, 1'b0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cyc(RSPC_OP_NONE, 21'h00_0000, a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    cyc(RSPC_OP_NONE, 21'h00_0000, a, 8'h00, 1'b0, 1'b1);
    chk({16'h0000, rdata}, {16'h0000, e});
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1;
    bench_rst <= 1'b0;
    por_rst <= 1'b0;
    rd(ADDR_STACK_PTR, 8'h00);
    rd(4'h9, 8'h00);
    op(RSPC_OP_JUMP, 21'h12_3456);
    chk(pc, 21'h12_3456);
    op(RSPC_OP_STEP, 21'h00_0000);
    chk(pc, 21'h12_3458);
    rd(ADDR_PC_LOW, 8'h58);
    rd(ADDR_PC_HIGH_LATCH, 8'h34);
    rd(ADDR_PC_UPPER_LATCH, 8'h12);
    wr(ADDR_PC_HIGH_LATCH, 8'hab);
    wr(ADDR_PC_UPPER_LATCH, 8'h05);
    wr(ADDR_PC_LOW, 8'h11);
    chk(pc, 21'h05_ab10);
    op(RSPC_OP_CALL, 21'h00_0100);
    rd(ADDR_STACK_PTR, 8'h01);
    rd(ADDR_TOP_LOW, 8'h10);
    rd(ADDR_TOP_HIGH, 8'hab);
    wr(ADDR_TOP_LOW, 8'h44);
    op(RSPC_OP_PUSH, 21'h00_0000);
    rd(ADDR_TOP_HIGH, 8'h01);
    op(RSPC_OP_POP, 21'h00_0000);
    rd(ADDR_STACK_PTR, 8'h01);
    op(RSPC_OP_RETURN, 21'h00_0000);
    chk(pc, 21'h05_ab44);
    wr(ADDR_STACK_PTR, 8'h03);
    rd(ADDR_STACK_PTR, 8'h03);
    wr(ADDR_STACK_PTR, 8'h00);
    ctx_in <= 24'h12_3456;
    cmd.irq_vector <= 1'b1;
    op(RSPC_OP_CALL, 21'h00_0008);
    cmd.irq_vector <= 1'b0;
    ctx_in <= 24'h65_4321;
    cmd.fast_return <= 1'b1;
    op(RSPC_OP_RETURN, 21'h00_0000);
    cmd.fast_return <= 1'b0;
    chk(ctx_r, 24'h12_3456);
    chk({23'h00_0000, ctx_v}, 24'h00_0001);
    op(RSPC_OP_RETURN, 21'h00_0000);
    chk(pc, 21'h00_0000);
    rd(ADDR_STACK_PTR, 8'h40);
    bench_rst <= 1'b1;
    op(RSPC_OP_NONE, 21'h00_0000);
    bench_rst <= 1'b0;
    rd(ADDR_STACK_PTR, 8'h40);
    wr(ADDR_STACK_PTR, 8'h00);
    for (int i = 0; i < 31; i++) op(RSPC_OP_CALL, 21'(i * 4));
    rd(ADDR_STACK_PTR, 8'h9f);
    op(RSPC_OP_CALL, 21'h00_0200);
    rd(ADDR_STACK_PTR, 8'h9f);
    rd(ADDR_TOP_LOW, 8'h74);
    bench_rst <= 1'b1;
    por_rst <= 1'b1;
    en <= 1'b1;
    op(RSPC_OP_NONE, 21'h00_0000);
    bench_rst <= 1'b0;
    por_rst <= 1'b0;
    rd(ADDR_STACK_PTR, 8'h00);
    for (int i = 0; i < 31; i++) op(RSPC_OP_CALL, 21'(i * 4));
    k = 0;
    while (rst_req !== 1'b1 && k < 4) begin
      op(RSPC_OP_NONE, 21'h00_0000);
      k++;
    end
    chk({23'h00_0000, rst_req}, 24'h00_0001);
    if (rst_req !== 1'b1) finish_test();
    op(RSPC_OP_NONE, 21'h00_0000);
    rd(ADDR_STACK_PTR, 8'h80);
    wr(ADDR_STACK_PTR, 8'h1f);
    rd(ADDR_TOP_LOW, 8'h76);
    wr(ADDR_STACK_PTR, 8'h00);
    op(RSPC_OP_RETURN, 21'h00_0000);
    chk({23'h00_0000, rst_req}, 24'h00_0001);
    op(RSPC_OP_NONE, 21'h00_0000);
    rd(ADDR_STACK_PTR, 8'h40);
    finish_test();
  end
endmodule
bind rspc_unit rspc_unit_checker #(.DEPTH(DEPTH)) i_chk (
  .clock(clock),
  .sys_rst(sys_rst),
  .por_rst(por_rst),
  .stack_error_reset_enable(stack_error_reset_enable),
  .cmd(cmd),
  .bus(bus),
  .ctx_restore_valid(ctx_restore_valid),
  .pc(pc),
  .rdata(rdata),
  .device_reset_req(device_reset_req)
);
